/* File: logic/dcc_pkg.sv */
package dcc_pkg;
    // register indices; byte address is index * 4
    localparam logic [8:0]  REG_CTRL_IDX    = 9'h130;
    localparam logic [8:0]  REG_STATUS_IDX  = 9'h131;
    localparam logic [8:0]  REG_ERRADR_IDX  = 9'h132;
    localparam logic [8:0]  REG_DROPADR_IDX = 9'h133;
    localparam logic [8:0]  REG_ORDER_IDX   = 9'h134;
    localparam int          ADDR_W          = 11;
    localparam logic [10:0] ADDR_CTRL       = {REG_CTRL_IDX, 2'b00};
    localparam logic [10:0] ADDR_STATUS     = {REG_STATUS_IDX, 2'b00};
    localparam logic [10:0] ADDR_ERRADR     = {REG_ERRADR_IDX, 2'b00};
    localparam logic [10:0] ADDR_DROPADR    = {REG_DROPADR_IDX, 2'b00};
    localparam logic [10:0] ADDR_ORDER      = {REG_ORDER_IDX, 2'b00};
    // control bits
    localparam int C_ECC    = 0;
    localparam int C_AUTO   = 1;
    localparam int C_SBE    = 2;
    localparam int C_DBE    = 3;
    localparam int C_IRQ    = 4;
    localparam int C_MSBE   = 5;
    localparam int C_MDBE   = 6;
    localparam int C_CLR    = 7;
    localparam int C_MDROP  = 8;
    localparam int CTRL_W   = 9;
    localparam logic [8:0] CTRL_RESET = 9'h013;
    // status layout
    localparam int S_SBE    = 0;
    localparam int S_DBE    = 1;
    localparam int S_DROP   = 2;
    localparam int ORD_BIT  = 0;
    localparam int STV_LO   = 16;
    localparam int STV_HI   = 23;
    localparam int DATA_W   = 32;
    localparam int CMD_AW   = 32;
    localparam logic [7:0]  TALLY_TOP  = 8'hff;
    localparam logic [7:0]  STV_RESET  = 8'h00;
    localparam logic [31:0] ZERO32     = 32'h0000_0000;
    localparam logic [31:0] INJ1_MASK  = 32'h0000_0001;
    localparam logic [31:0] INJ2_MASK  = 32'h0000_0003;
    typedef enum logic [4:0] {
        DCC_IDLE  = 5'b00001,
        DCC_POOL  = 5'b00010,
        DCC_GRANT = 5'b00100,
        DCC_ISSUE = 5'b01000,
        DCC_RMW   = 5'b10000
    } dcc_state_t;
endpackage : dcc_pkg

/* File: logic/dcc_ctrl.sv */
`timescale 1ns/1ps
// Function
// - control bit 0 enables ecc checking, resets to one, only if built with ecc.
// - control bit 1 corrects single-bit errors automatically while ecc is active.
// - control bit 2 flips data bit 0 on writes.
// - control bit 3 flips data bits 0 and 1 on writes.
// - control bit 4 gates the interrupt output, resets to one.
// - control bit 5 masks single-bit error interrupts.
// - control bit 6 masks double-bit error interrupts.
// - writing one to bit 7 clears irq, flags, tallies, addresses; self-clears.
// - control bit 8 masks dropped-correction interrupts.
// - status bit 0 sticks on any single-bit error seen while ecc is active, until cleared.
// - status bit 1 sticks on any double-bit error seen while ecc is active, until cleared.
// - status bit 2 sets when a self-scheduled correction is dropped.
// - status 15:8 counts single-bit errors since clear.
// - status 23:16 counts double-bit errors since clear.
// - status 31:24 counts dropped corrections since clear.
// - read-only register holds burst address of latest ecc error.
// - read-only register holds burst address of latest dropped correction.
// - bits 23:16 set how many commands may pass a starved command.
// - pool forwards a write only when timing met and write data ready.
// - arbiter grants only when rank timing met, then issues to phy port.
// - phy port fetches write data and presents command and data together.
// - phy read data goes through read buffer back to the master.
// - read-modify-write for partial writes with ecc and for corrections.
module dcc_ctrl #(
    parameter bit ECC_PRESENT = 1'b1
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire logic [dcc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    input  wire logic                       cmd_valid,
    input  wire logic                       cmd_write,
    input  wire logic                       cmd_partial,
    input  wire logic [dcc_pkg::CMD_AW-1:0] cmd_addr,
    input  wire logic [dcc_pkg::DATA_W-1:0] cmd_wdata,
    output logic                            cmd_ready,
    output logic                            rd_valid,
    output logic      [dcc_pkg::DATA_W-1:0] rd_data,
    input  wire logic                       bank_timing_ok,
    input  wire logic                       rank_timing_ok,
    output logic                            phy_cmd_valid,
    output logic                            phy_cmd_write,
    output logic      [dcc_pkg::CMD_AW-1:0] phy_cmd_addr,
    output logic      [dcc_pkg::DATA_W-1:0] phy_wdata,
    input  wire logic                       phy_rd_valid,
    input  wire logic [dcc_pkg::DATA_W-1:0] phy_rd_data,
    input  wire logic                       phy_rd_sbe,
    input  wire logic                       phy_rd_dbe,
    input  wire logic                       fix_dropped,
    output logic                            ecc_active,
    output logic                            return_order_select,
    output logic      [7:0]                 starvation_threshold,
    output logic                            irq
);
    import dcc_pkg::*;

    logic [CTRL_W-1:0] ctrl_reg;
    logic              single_fault_flag_reg, double_fault_flag_reg, dropped_fix_flag_reg;
    logic [7:0]        single_fault_tally_reg, double_fault_tally_reg, dropped_fix_tally_reg;
    logic [31:0]       last_error_location_reg, last_dropped_fix_location_reg;
    logic              order_reg;
    logic [7:0]        stv_reg;
    dcc_state_t        state_reg;
    logic              is_write_reg, is_rmw_reg, fix_pend_reg, wdata_ready_reg;
    logic [31:0]       addr_reg, wbuf_reg;
    logic              wr_ctrl, clear_hit, sbe_ev, dbe_ev, drop_ev;
    logic              irq_next;
    logic [31:0]       inj_mask;

    assign wr_ctrl   = clk_en && reg_wr && reg_addr == ADDR_CTRL;
    assign clear_hit = wr_ctrl && reg_wdata[C_CLR];
    // errors only count while checking is live
    assign sbe_ev    = clk_en && phy_rd_valid && phy_rd_sbe && ecc_active;
    assign dbe_ev    = clk_en && phy_rd_valid && phy_rd_dbe && ecc_active;
    assign drop_ev   = clk_en && fix_dropped;

    // control register; clear bit never stored so it reads back zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg         <= reg_wdata[CTRL_W-1:0];
            ctrl_reg[C_CLR]  <= 1'b0;
        end
    end

    // ecc only effective when the build carries it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ecc_active <= 1'b0;
        end else if (clk_en) begin
            ecc_active <= ECC_PRESENT && ctrl_reg[C_ECC];
        end
    end

    // sticky flags; event beats a simultaneous clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_fault_flag_reg <= 1'b0;
            double_fault_flag_reg <= 1'b0;
            dropped_fix_flag_reg  <= 1'b0;
        end else begin
            if (sbe_ev) single_fault_flag_reg <= 1'b1;
            else if (clear_hit) single_fault_flag_reg <= 1'b0;
            if (dbe_ev) double_fault_flag_reg <= 1'b1;
            else if (clear_hit) double_fault_flag_reg <= 1'b0;
            if (drop_ev) dropped_fix_flag_reg <= 1'b1;
            else if (clear_hit) dropped_fix_flag_reg <= 1'b0;
        end
    end

    // saturating tallies; an event during clear restarts at one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_fault_tally_reg <= 8'h00;
            double_fault_tally_reg <= 8'h00;
            dropped_fix_tally_reg  <= 8'h00;
        end else begin
            if (clear_hit) single_fault_tally_reg <= {7'h00, sbe_ev};
            else if (sbe_ev && single_fault_tally_reg != TALLY_TOP)
                single_fault_tally_reg <= single_fault_tally_reg + 8'h01;
            if (clear_hit) double_fault_tally_reg <= {7'h00, dbe_ev};
            else if (dbe_ev && double_fault_tally_reg != TALLY_TOP)
                double_fault_tally_reg <= double_fault_tally_reg + 8'h01;
            if (clear_hit) dropped_fix_tally_reg <= {7'h00, drop_ev};
            else if (drop_ev && dropped_fix_tally_reg != TALLY_TOP)
                dropped_fix_tally_reg <= dropped_fix_tally_reg + 8'h01;
        end
    end

    // captured addresses of the latest error and dropped fix
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_error_location_reg       <= ZERO32;
            last_dropped_fix_location_reg <= ZERO32;
        end else begin
            if (sbe_ev || dbe_ev) last_error_location_reg <= addr_reg;
            else if (clear_hit) last_error_location_reg <= ZERO32;
            if (drop_ev) last_dropped_fix_location_reg <= addr_reg;
            else if (clear_hit) last_dropped_fix_location_reg <= ZERO32;
        end
    end

    // ordering and starvation register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            order_reg <= 1'b0;
            stv_reg   <= STV_RESET;
        end else if (clk_en && reg_wr && reg_addr == ADDR_ORDER) begin
            order_reg <= reg_wdata[ORD_BIT];
            stv_reg   <= reg_wdata[STV_HI:STV_LO];
        end
    end
    assign return_order_select  = order_reg;
    assign starvation_threshold = stv_reg;

    // register read port, data one cycle after strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= ZERO32;
        end else if (clk_en) begin
            if (!reg_rd) reg_rdata <= ZERO32;
            else if (reg_addr == ADDR_CTRL) reg_rdata <= {23'h000000, ctrl_reg};
            else if (reg_addr == ADDR_STATUS)
                reg_rdata <= {dropped_fix_tally_reg, double_fault_tally_reg, single_fault_tally_reg,
                              5'h00, dropped_fix_flag_reg, double_fault_flag_reg, single_fault_flag_reg};
            else if (reg_addr == ADDR_ERRADR) reg_rdata <= last_error_location_reg;
            else if (reg_addr == ADDR_DROPADR) reg_rdata <= last_dropped_fix_location_reg;
            else if (reg_addr == ADDR_ORDER) reg_rdata <= {8'h00, stv_reg, 15'h0000, order_reg};
            else reg_rdata <= ZERO32; // unmapped reads zero
        end
    end

    // interrupt: enable gate over unmasked sticky flags
    assign irq_next = ctrl_reg[C_IRQ] && !clear_hit &&
        ((single_fault_flag_reg && !ctrl_reg[C_MSBE]) ||
         (double_fault_flag_reg && !ctrl_reg[C_MDBE]) ||
         (dropped_fix_flag_reg  && !ctrl_reg[C_MDROP]));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) irq <= 1'b0;
        else if (clk_en) irq <= irq_next;
    end

    // test corruption applied to the outgoing write word
    assign inj_mask = ctrl_reg[C_DBE] ? INJ2_MASK : (ctrl_reg[C_SBE] ? INJ1_MASK : ZERO32);

    // command flow: one command at a time through pool, arbiter and phy port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= DCC_IDLE;
            is_write_reg    <= 1'b0;
            is_rmw_reg      <= 1'b0;
            fix_pend_reg    <= 1'b0;
            wdata_ready_reg <= 1'b0;
            addr_reg        <= ZERO32;
            wbuf_reg        <= ZERO32;
            cmd_ready       <= 1'b0;
            phy_cmd_valid   <= 1'b0;
            phy_cmd_write   <= 1'b0;
            phy_cmd_addr    <= ZERO32;
            phy_wdata       <= ZERO32;
            rd_valid        <= 1'b0;
            rd_data         <= ZERO32;
        end else if (clk_en) begin
            phy_cmd_valid <= 1'b0;
            rd_valid      <= 1'b0;
            cmd_ready     <= 1'b0;
            case (state_reg)
                DCC_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        addr_reg  <= cmd_addr;
                        wbuf_reg  <= cmd_wdata;
                        cmd_ready <= 1'b0;
                        // partial write with ecc becomes a read first
                        is_rmw_reg      <= cmd_write && cmd_partial && ecc_active;
                        is_write_reg    <= cmd_write && !(cmd_partial && ecc_active);
                        wdata_ready_reg <= cmd_write && !(cmd_partial && ecc_active);
                        state_reg       <= DCC_POOL;
                    end
                end
                DCC_POOL: begin
                    if (bank_timing_ok && (!is_write_reg || wdata_ready_reg)) state_reg <= DCC_GRANT;
                end
                DCC_GRANT: begin
                    if (rank_timing_ok) begin
                        phy_cmd_valid <= 1'b1;
                        phy_cmd_write <= is_write_reg;
                        phy_cmd_addr  <= addr_reg;
                        phy_wdata     <= is_write_reg ? (wbuf_reg ^ inj_mask) : ZERO32;
                        state_reg     <= is_write_reg ? DCC_IDLE : DCC_ISSUE;
                        if (is_write_reg) begin
                            is_rmw_reg   <= 1'b0;
                            fix_pend_reg <= 1'b0;
                        end
                    end
                end
                DCC_ISSUE: begin
                    if (phy_rd_valid) begin
                        if (is_rmw_reg || fix_pend_reg) begin
                            wbuf_reg  <= is_rmw_reg ? wbuf_reg : phy_rd_data;
                            state_reg <= DCC_RMW;
                        end else if (phy_rd_sbe && ctrl_reg[C_AUTO] && ecc_active) begin
                            rd_valid     <= 1'b1;
                            rd_data      <= phy_rd_data;
                            fix_pend_reg <= 1'b1;
                            wbuf_reg     <= phy_rd_data;
                            state_reg    <= DCC_RMW;
                        end else begin
                            rd_valid  <= 1'b1;
                            rd_data   <= phy_rd_data;
                            state_reg <= DCC_IDLE;
                        end
                    end
                end
                DCC_RMW: begin
                    // write data ready (no merge with read data): write back through the pool, or back to idle when fix_dropped
                    is_write_reg    <= 1'b1;
                    wdata_ready_reg <= 1'b1;
                    state_reg       <= fix_dropped ? DCC_IDLE : DCC_POOL;
                    if (fix_dropped) fix_pend_reg <= 1'b0;
                end
                default: state_reg <= DCC_IDLE;
            endcase
        end
    end

    // checks
    a_clear_flags: assert property (@(posedge clk) disable iff (!rst_n)
        clear_hit && !sbe_ev |=> !single_fault_flag_reg) else $error("flag not cleared");
    a_sbe_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        sbe_ev |=> single_fault_flag_reg) else $error("sbe flag missed");
    a_dbe_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        dbe_ev |=> double_fault_flag_reg) else $error("dbe flag missed");
    a_drop_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        drop_ev |=> dropped_fix_flag_reg) else $error("drop flag missed");
    a_tally_sat: assert property (@(posedge clk) disable iff (!rst_n)
        single_fault_tally_reg == TALLY_TOP && !clear_hit |=> single_fault_tally_reg == TALLY_TOP)
        else $error("tally wrapped");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !ctrl_reg[C_IRQ] |=> !irq) else $error("irq while disabled");
    a_irq_sbe_mask: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && ctrl_reg[C_MSBE] && !double_fault_flag_reg && !dropped_fix_flag_reg |=> !irq)
        else $error("masked sbe raised irq");
    a_grant_rank: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(phy_cmd_valid) |-> $past(rank_timing_ok)) else $error("grant without rank timing");
    a_ctrl_clr_self: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ctrl |=> !ctrl_reg[C_CLR]) else $error("clear bit stuck");
    c_write_issue: cover property (@(posedge clk) phy_cmd_valid && phy_cmd_write);
    c_read_return: cover property (@(posedge clk) rd_valid);
    c_rmw_seen: cover property (@(posedge clk) state_reg == DCC_RMW);
    c_irq_seen: cover property (@(posedge clk) irq);
endmodule : dcc_ctrl

/* File: dv/dcc_phy_model.sv */
`timescale 1ns/1ps
// memory behind the phy-side port; one read in flight, answered after 2 or 7 cycles
module dcc_phy_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        phy_cmd_valid,
    input  wire logic        phy_cmd_write,
    input  wire logic [31:0] phy_cmd_addr,
    input  wire logic [31:0] phy_wdata,
    input  wire logic [1:0]  err_sel,
    input  wire logic        slow,
    output logic             phy_rd_valid,
    output logic      [31:0] phy_rd_data,
    output logic             phy_rd_sbe,
    output logic             phy_rd_dbe
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] pend;
    int          cnt;
    // data toggles between returns so stale data never looks like a good answer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt          <= 0;
            phy_rd_valid <= 1'b0;
            phy_rd_data  <= 32'h0;
            phy_rd_sbe   <= 1'b0;
            phy_rd_dbe   <= 1'b0;
        end else begin
            phy_rd_valid <= 1'b0;
            phy_rd_sbe   <= 1'b0;
            phy_rd_dbe   <= 1'b0;
            phy_rd_data  <= ~phy_rd_data;
            if (phy_cmd_valid && phy_cmd_write) begin
                mem[phy_cmd_addr] = phy_wdata;
            end
            if (phy_cmd_valid && !phy_cmd_write) begin
                pend <= phy_cmd_addr;
                cnt  <= slow ? 7 : 2;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    phy_rd_valid <= 1'b1;
                    phy_rd_data  <= mem.exists(pend) ? mem[pend] : ~pend;
                    phy_rd_sbe   <= (err_sel == 2'h1);
                    phy_rd_dbe   <= (err_sel == 2'h2);
                end
            end
        end
    end
endmodule : dcc_phy_model

/* File: dv/dcc_ctrl_tb.sv */
`timescale 1ns/1ps
module dcc_ctrl_tb;
    import dcc_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    logic        clk, rst_n, reg_wr, reg_rd, cmd_valid, cmd_write, cmd_partial, cmd_ready, rd_valid, slow;
    logic        bank_ok, rank_ok, phy_cmd_valid, phy_cmd_write, phy_rd_valid, phy_rd_sbe, phy_rd_dbe;
    logic        fix_dropped, ecc_active, return_order_select, irq;
    logic [1:0]  err_sel;
    logic [7:0]  starvation_threshold;
    logic [10:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cmd_addr, cmd_wdata, rd_data, phy_cmd_addr, phy_wdata, phy_rd_data, d;
    int          n_fail = 0;
    int          num_checks = 0;
    dcc_ctrl u_dcc_ctrl (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_partial(cmd_partial), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .bank_timing_ok(bank_ok), .rank_timing_ok(rank_ok),
        .phy_cmd_valid(phy_cmd_valid), .phy_cmd_write(phy_cmd_write), .phy_cmd_addr(phy_cmd_addr),
        .phy_wdata(phy_wdata), .phy_rd_valid(phy_rd_valid), .phy_rd_data(phy_rd_data), .phy_rd_sbe(phy_rd_sbe),
        .phy_rd_dbe(phy_rd_dbe), .fix_dropped(fix_dropped), .ecc_active(ecc_active),
        .return_order_select(return_order_select), .starvation_threshold(starvation_threshold), .irq(irq));
    dcc_phy_model u_dcc_phy_model (.clk(clk), .rst_n(rst_n), .phy_cmd_valid(phy_cmd_valid),
        .phy_cmd_write(phy_cmd_write), .phy_cmd_addr(phy_cmd_addr), .phy_wdata(phy_wdata), .err_sel(err_sel),
        .slow(slow), .phy_rd_valid(phy_rd_valid), .phy_rd_data(phy_rd_data), .phy_rd_sbe(phy_rd_sbe),
        .phy_rd_dbe(phy_rd_dbe));
    // 200 mhz
    always #2.5 clk = ~clk;
    task automatic conclude;
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic lost(input string what);
        n_fail++;
        $display("[FAIL] %0t %s: wait ran out", $time, what);
        conclude();
    endtask : lost
    task automatic reg_write(input logic [10:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write
    // read data stands only in the cycle after the strobe
    task automatic reg_check(input logic [10:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata & m, e, what);
    endtask : reg_check
    task automatic send_cmd(input logic w, input logic p, input logic [31:0] a, input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        cmd_valid   <= 1'b1;
        cmd_write   <= w;
        cmd_partial <= p;
        cmd_addr    <= a;
        cmd_wdata   <= v;
        for (int i = 0; i < 100 && !ok; i++) begin
            #1 ok = cmd_ready;
            @(posedge clk);
        end
        // released lines carry garbage, not the last request
        cmd_valid <= 1'b0;
        cmd_addr  <= ~a;
        cmd_wdata <= ~v;
        if (!ok) lost("command");
    endtask : send_cmd
    task automatic expect_phy(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            #1;
            if (phy_cmd_valid === 1'b1) begin
                chk({31'h0, phy_cmd_write}, {31'h0, w}, "phy kind");
                chk(phy_cmd_addr, a, "phy addr");
                chk(phy_wdata & m, v & m, "phy data");
                return;
            end
        end
        lost("phy command");
    endtask : expect_phy
    // hb holds bank timing once the read is out, so a write-back stays pending
    task automatic read_cmd(input logic [31:0] a, input logic [1:0] e, input logic hb);
        @(posedge clk);
        err_sel <= e;
        send_cmd(1'b0, 1'b0, a, 32'h0);
        expect_phy(1'b0, a, 32'h0, 32'h0);
        @(posedge clk);
        bank_ok <= !hb;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1) begin
                d = rd_data;
                err_sel <= 2'h0;
                return;
            end
        end
        lost("read data");
    endtask : read_cmd
    task automatic quiet(input string what);
        repeat (6) begin
            @(posedge clk);
            #1;
            chk({31'h0, phy_cmd_valid}, 32'h0, what);
        end
    endtask : quiet
    task automatic irq_is(input logic e, input string what);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, e}, what);
    endtask : irq_is
    task automatic t_reset;
        chk({31'h0, ecc_active}, 32'h1, "ecc active");
        reg_check(ADDR_CTRL, ALL, 32'h0000_0013, "ctrl reset");
        reg_write(ADDR_STATUS, ALL);
        reg_check(ADDR_STATUS, ALL, 32'h0, "status");
        reg_check(ADDR_ERRADR, ALL, 32'h0, "err addr");
        reg_check(ADDR_DROPADR, ALL, 32'h0, "drop addr");
        reg_check(11'h4d4, ALL, 32'h0, "unmapped");
        reg_check(ADDR_ORDER, 32'h00ff_0000, 32'h0, "starve reset");
    endtask : t_reset
    task automatic t_write_path;
        logic [31:0] ctl [4] = '{32'h13, 32'h17, 32'h1b, 32'h1f};
        logic [31:0] msk [4] = '{ZERO32, INJ1_MASK, INJ2_MASK, INJ2_MASK};
        for (int i = 0; i < 4; i++) begin
            reg_write(ADDR_CTRL, ctl[i]);
            @(posedge clk);
            bank_ok <= 1'b0;
            rank_ok <= 1'b0;
            send_cmd(1'b1, 1'b0, 32'h200 + i * 32'h20, 32'h5a5a_f0f0);
            quiet("bank held");
            @(posedge clk);
            bank_ok <= 1'b1;
            quiet("rank held");
            @(posedge clk);
            rank_ok <= 1'b1;
            expect_phy(1'b1, 32'h200 + i * 32'h20, 32'h5a5a_f0f0 ^ msk[i], ALL);
        end
        reg_write(ADDR_CTRL, 32'h13);
    endtask : t_write_path
    task automatic t_read_path;
        send_cmd(1'b1, 1'b0, 32'h40, 32'h1234_5678);
        expect_phy(1'b1, 32'h40, 32'h1234_5678, ALL);
        slow <= 1'b1;
        read_cmd(32'h40, 2'h0, 1'b0);
        slow <= 1'b0;
        chk(d, 32'h1234_5678, "read data");
    endtask : t_read_path
    task automatic t_single;
        send_cmd(1'b1, 1'b0, 32'h80, 32'h0000_00f0);
        expect_phy(1'b1, 32'h80, 32'h0000_00f0, ALL);
        read_cmd(32'h80, 2'h1, 1'b0);
        expect_phy(1'b1, 32'h80, 32'h0000_00f0, ALL);
        reg_check(ADDR_STATUS, ALL, 32'h0000_0101, "sbe status");
        reg_check(ADDR_ERRADR, ALL, 32'h80, "sbe addr");
        irq_is(1'b1, "sbe irq");
        reg_write(ADDR_CTRL, 32'h33);
        irq_is(1'b0, "sbe masked");
        reg_write(ADDR_CTRL, 32'h03);
        irq_is(1'b0, "irq off");
        reg_write(ADDR_CTRL, 32'h93);
        reg_check(ADDR_STATUS, ALL, 32'h0, "status clear");
        reg_check(ADDR_ERRADR, ALL, 32'h0, "addr clear");
        reg_check(ADDR_CTRL, ALL, 32'h13, "clear bit");
        irq_is(1'b0, "irq clear");
    endtask : t_single
    task automatic t_double;
        reg_write(ADDR_CTRL, 32'h11);
        read_cmd(32'h40, 2'h2, 1'b0);
        quiet("no fix");
        reg_check(ADDR_STATUS, ALL, 32'h0001_0002, "dbe status");
        reg_check(ADDR_ERRADR, ALL, 32'h40, "dbe addr");
        irq_is(1'b1, "dbe irq");
        reg_write(ADDR_CTRL, 32'h51);
        irq_is(1'b0, "dbe masked");
        reg_write(ADDR_CTRL, 32'h93);
    endtask : t_double
    task automatic t_dropped;
        read_cmd(32'h80, 2'h1, 1'b1);
        fix_dropped <= 1'b1;
        @(posedge clk);
        fix_dropped <= 1'b0;
        bank_ok     <= 1'b1;
        quiet("aborted fix");
        reg_check(ADDR_STATUS, ALL, 32'h0100_0105, "drop status");
        reg_check(ADDR_DROPADR, ALL, 32'h80, "drop addr");
        reg_write(ADDR_CTRL, 32'h33);
        irq_is(1'b1, "drop irq");
        reg_write(ADDR_CTRL, 32'h133);
        irq_is(1'b0, "drop masked");
        reg_write(ADDR_CTRL, 32'h93);
    endtask : t_dropped
    task automatic t_saturate;
        reg_write(ADDR_CTRL, 32'h11);
        repeat (257) read_cmd(32'h40, 2'h2, 1'b0);
        reg_check(ADDR_STATUS, ALL, 32'h00ff_0002, "tally");
        reg_write(ADDR_CTRL, 32'h93);
    endtask : t_saturate
    task automatic t_ecc_off;
        reg_write(ADDR_CTRL, 32'h12);
        read_cmd(32'h80, 2'h1, 1'b0);
        quiet("fix with ecc off");
        chk({31'h0, ecc_active}, 32'h0, "ecc off");
        reg_check(ADDR_STATUS, ALL, 32'h0, "ecc off status");
        reg_write(ADDR_CTRL, 32'h13);
    endtask : t_ecc_off
    task automatic t_partial;
        send_cmd(1'b1, 1'b1, 32'h140, 32'ha5a5_0f0f);
        expect_phy(1'b0, 32'h140, 32'h0, 32'h0);
        expect_phy(1'b1, 32'h140, 32'ha5a5_0f0f, ALL);
    endtask : t_partial
    task automatic t_order;
        reg_write(ADDR_ORDER, 32'h0037_0001);
        reg_check(ADDR_ORDER, 32'h00ff_0001, 32'h0037_0001, "order reg");
        chk({23'h0, starvation_threshold, return_order_select}, 32'h6f, "starve out");
    endtask : t_order
    initial begin
        clk = 1'b0;
        {rst_n, reg_wr, reg_rd, cmd_valid, cmd_write, cmd_partial, fix_dropped, slow} = 8'h00;
        {bank_ok, rank_ok} = 2'h3;
        err_sel = 2'h0;
        reg_addr = 11'h000;
        {reg_wdata, cmd_addr, cmd_wdata} = 96'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_write_path();
        t_read_path();
        t_single();
        t_double();
        t_dropped();
        t_saturate();
        t_ecc_off();
        t_partial();
        t_order();
        conclude();
    end
endmodule : dcc_ctrl_tb
